// ===== bench/strap_board.sv
// board strap ties of the video switch, one tie word fans out to the pins
// assumes the bench changes the tie word only between checks
`timescale 1ns/1ps

module strap_board
(
	// tie word from the bench
	input  wire logic [7:0] tie,
	// strap pins
	output wire logic       strap_hs_enable,
	output wire logic [1:0] strap_source_sel,
	output wire logic       strap_eq_level,
	output wire logic [1:0] strap_preemph_bits,
	output wire logic       strap_output_term,
	output wire logic       strap_output_current
);
	// hard ties to a rail, never left floating, so no pull level is modelled
	assign {strap_output_current, strap_output_term, strap_preemph_bits, strap_eq_level,
		strap_source_sel, strap_hs_enable} = tie;
endmodule // strap_board

// ===== bench/tb.sv
// self-checking bench for the video switch configuration registers
// drives the register port and the strap board at the falling edge
`timescale 1ns/1ps

module tb;
	localparam int PLEN  = 20;
	localparam int LIMIT = 3000;
	logic        clk = 1'b0;
	logic        rstn = 1'b0;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [7:0]  reg_addr = 8'h00;
	logic [7:0]  reg_wdata = 8'h00;
	logic [7:0]  tie = 8'h00;
	logic [7:0]  rdata, rdv;
	logic        s_en, s_eq, s_ot, s_oc, serial_mode, hs_enable, oterm, ocurr;
	logic [1:0]  s_src, s_pe, hs_src, preemph;
	logic [3:0]  aux, term_a, term_b, term_c, term_d, eq_a, eq_b, eq_c, eq_d;
	logic [10:0] ev;
	logic [15:0] v;
	int          failures = 0;
	int          cmp_count = 0;
	int          cyc = 0;
	int          n;
	logic [7:0]  ties [4] = '{8'h00, 8'hFF, 8'h5A, 8'hA5};
	logic [7:0]  ofs [8] = '{8'h00, 8'h01, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h20};
	wire logic [10:0] ctl_v = {hs_enable, hs_src, aux, preemph, oterm, ocurr};
	wire logic [15:0] term_v = {term_a, term_b, term_c, term_d};
	wire logic [15:0] eq_v = {eq_a, eq_b, eq_c, eq_d};

	strap_board i_board (.tie(tie), .strap_hs_enable(s_en), .strap_source_sel(s_src),
		.strap_eq_level(s_eq), .strap_preemph_bits(s_pe), .strap_output_term(s_ot),
		.strap_output_current(s_oc));
	vswitch_cfg_regs #(.PULSE_LEN(PLEN)) i_dut (.clk(clk), .rstn(rstn), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(rdata),
		.strap_hs_enable(s_en), .strap_source_sel(s_src), .strap_eq_level(s_eq),
		.strap_preemph_bits(s_pe), .strap_output_term(s_ot), .strap_output_current(s_oc),
		.serial_mode(serial_mode), .hs_enable(hs_enable), .hs_source_sel(hs_src),
		.aux_connect(aux), .term_connect_a(term_a), .term_connect_b(term_b),
		.term_connect_c(term_c), .term_connect_d(term_d), .eq_high_a(eq_a), .eq_high_b(eq_b),
		.eq_high_c(eq_c), .eq_high_d(eq_d), .preemph_level(preemph),
		.output_term_on(oterm), .output_current_sel(ocurr));

	// ----------------------------------------------------------------------
	// clock, hang guard and shared tasks
	// ----------------------------------------------------------------------
	always #2 clk = ~clk;
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == LIMIT)
		begin
			failures++;
			finish_test();
		end
	end

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			failures++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// one-cycle strobe; no settle so pulse timing can be watched from the edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge clk);
		reg_wr = 1'b0;
	endtask

	task automatic ws(input logic [7:0] a, input logic [7:0] d);
		wr(a, d);
		repeat (2) @(negedge clk);
	endtask

	task automatic rd(input logic [7:0] a);
		reg_rd = 1'b1;
		reg_addr = a;
		@(negedge clk);
		reg_rd = 1'b0;
		repeat (2) @(negedge clk);
		rdv = rdata;
	endtask

	// lane vector packed {a, b, c, d}, bit n of each group is lane n
	function automatic logic [15:0] lane(input int i);
		lane = 16'h0000;
		lane[(i < 8) ? 8 + i : 15 - i] = 1'b1;
	endfunction

	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// ----------------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------------
	initial
	begin
		repeat (16) @(negedge clk);
		rstn = 1'b1;
		repeat (4) @(negedge clk);
		// strap mode, every source code and both levels of each strap
		for (int k = 0; k < 4; k++)
		begin
			tie = ties[k];
			repeat (2) @(negedge clk);
			ev = {tie[0], tie[2:1], 4'h1 << tie[2:1], tie[5:4], tie[6], tie[7]};
			chk({5'h00, ctl_v}, {5'h00, ev});
			chk(term_v, 16'hFFFF);
			chk(eq_v, {16{tie[3]}});
			chk({15'h0000, serial_mode}, 16'h0000);
		end
		// first access hands control to the registers, straps then ignored
		rd(8'h20);
		tie = 8'h5A;
		repeat (2) @(negedge clk);
		chk({15'h0000, serial_mode}, 16'h0001);
		chk({5'h00, ctl_v}, {5'h00, 1'b1, 2'h0, 4'h1, 2'h0, 2'h3});
		for (int k = 0; k < 8; k++)
		begin
			rd(ofs[k]);
			chk({8'h00, rdv}, {8'h00, vswitch_cfg_pkg::RST_VAL[k]});
			ws(ofs[k], 8'hFF);
			rd(ofs[k]);
			chk({8'h00, rdv}, {8'h00, vswitch_cfg_pkg::WR_MASK[k]});
		end
		ws(8'h05, 8'hFF);
		rd(8'h05);
		chk({8'h00, rdv}, 16'h0000);
		for (int k = 0; k < 4; k++)
		begin
			ws(8'h01, 8'h40 | 8'(k));
			chk({12'h000, aux}, {12'h000, 4'h1 << k});
		end
		ws(8'h01, 8'h03);
		chk({12'h000, aux}, 16'h0000);
		for (int k = 0; k < 16; k++)
		begin
			ws(8'h20, 8'(k));
			chk({12'h000, preemph, oterm, ocurr}, 16'(k));
			v = 16'h0001 << k;
			ws(8'h13, v[7:0]);
			ws(8'h14, v[15:8]);
			chk(eq_v, lane(k));
		end
		// pulse lanes a0 and d0 only, then switch source three to one
		ws(8'h11, 8'h10);
		ws(8'h12, 8'h80);
		wr(8'h00, 8'h41);
		for (int w = 0; w < 8 && term_a[0] !== 1'b0; w++)
			@(negedge clk);
		chk(term_v, ~(lane(4) | lane(15)));
		n = 0;
		while (term_a[0] === 1'b0 && n < 100)
		begin
			n++;
			@(negedge clk);
		end
		// open for exactly the pulse length: PLEN cycles stand for the full 100 ms
		chk(16'(n), 16'(PLEN));
		chk(term_v, 16'hFFFF);
		ws(8'h10, 8'h00);
		chk(term_v, 16'h0000);
		finish_test();
	end
endmodule // tb

// ===== bench/vswitch_cfg_props.sv
// port assertions for the video switch configuration register bank
// bound into vswitch_cfg_regs; straps are static ties, port driven off-edge
`timescale 1ns/1ps

module vswitch_cfg_props
#(
	parameter int PULSE_LEN = 20
)
(
	// clock and reset
	input wire logic        clk,
	input wire logic        rstn,
	// register port
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [7:0]  reg_addr,
	input wire logic [7:0]  reg_wdata,
	input wire logic [7:0]  reg_rdata,
	// straps
	input wire logic        strap_hs_enable,
	input wire logic [1:0]  strap_source_sel,
	input wire logic        strap_eq_level,
	input wire logic [1:0]  strap_preemph_bits,
	input wire logic        strap_output_term,
	input wire logic        strap_output_current,
	// switch controls
	input wire logic        serial_mode,
	input wire logic        hs_enable,
	input wire logic [1:0]  hs_source_sel,
	input wire logic [3:0]  aux_connect,
	input wire logic [3:0]  term_connect_a,
	input wire logic [3:0]  term_connect_b,
	input wire logic [3:0]  term_connect_c,
	input wire logic [3:0]  term_connect_d,
	input wire logic [3:0]  eq_high_a,
	input wire logic [3:0]  eq_high_b,
	input wire logic [3:0]  eq_high_c,
	input wire logic [3:0]  eq_high_d,
	input wire logic [1:0]  preemph_level,
	input wire logic        output_term_on,
	input wire logic        output_current_sel
);
	// ----------------------------------------------------------------------
	// helpers: strap checks wait out the two-flop reset release
	// ----------------------------------------------------------------------
	logic [1:0] age_q;
	logic       used_q;
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			age_q  <= 2'h0;
			used_q <= 1'b0;
		end
		else
		begin
			age_q  <= (age_q == 2'h3) ? age_q : age_q + 2'h1;
			used_q <= used_q | reg_wr | reg_rd;
		end
	end
	wire logic strap_ok = (age_q == 2'h3) && !used_q && !reg_wr && !reg_rd;
	wire logic unmapped = !(reg_addr inside {8'h00, 8'h01, 8'h10, 8'h11, 8'h12, 8'h13,
		8'h14, 8'h20});

	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);

	// ----------------------------------------------------------------------
	// register writes reach the outputs two edges on
	// ----------------------------------------------------------------------
	tx_write_a: assert property (reg_wr && reg_addr == 8'h20 |=> ##1
		{4'h0, preemph_level, output_term_on, output_current_sel} == ($past(reg_wdata, 2) & 8'h0F))
		else $error("transmitter outputs differ from written value");
	aux_write_a: assert property (reg_wr && reg_addr == 8'h01 |=> ##1 aux_connect ==
		($past(reg_wdata[6], 2) ? 4'h1 << $past(reg_wdata[1:0], 2) : 4'h0))
		else $error("aux connection differs from written code");
	term_off_a: assert property (reg_wr && reg_addr == 8'h10 && !reg_wdata[0] |=> ##1
		{term_connect_a, term_connect_b, term_connect_c, term_connect_d} == 16'h0000)
		else $error("input terminations not all open");
	serial_set_a: assert property ((reg_wr || reg_rd) |=> ##1 serial_mode)
		else $error("serial mode not entered after access");
	serial_keep_a: assert property (serial_mode |=> serial_mode)
		else $error("serial mode dropped without reset");
	unmapped_rd_a: assert property (reg_rd && unmapped ##1 !reg_rd |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	// straps sampled in one cycle appear at the outputs in the next
	strap_src_a: assert property (strap_ok |=> hs_source_sel == $past(strap_source_sel)
		&& aux_connect == 4'h1 << $past(strap_source_sel))
		else $error("strap source not followed");
	strap_rx_a: assert property (strap_ok |=>
		{term_connect_a, term_connect_b, term_connect_c, term_connect_d} == 16'hFFFF
		&& {eq_high_a, eq_high_b, eq_high_c, eq_high_d} == {16{$past(strap_eq_level)}})
		else $error("strap receiver settings wrong");
	strap_tx_a: assert property (strap_ok |=> hs_enable == $past(strap_hs_enable)
		&& preemph_level == $past(strap_preemph_bits) && output_term_on == $past(strap_output_term)
		&& output_current_sel == $past(strap_output_current))
		else $error("strap transmitter settings wrong");

	cover property (serial_mode && $fell(term_connect_a[0]));
	cover property (strap_ok ##1 hs_source_sel == 2'h3);
	cover property (reg_rd && unmapped);
endmodule // vswitch_cfg_props

bind vswitch_cfg_regs vswitch_cfg_props #(.PULSE_LEN(PULSE_LEN)) i_props (
	.clk(clk), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .strap_hs_enable(strap_hs_enable),
	.strap_source_sel(strap_source_sel), .strap_eq_level(strap_eq_level),
	.strap_preemph_bits(strap_preemph_bits), .strap_output_term(strap_output_term),
	.strap_output_current(strap_output_current), .serial_mode(serial_mode),
	.hs_enable(hs_enable), .hs_source_sel(hs_source_sel), .aux_connect(aux_connect),
	.term_connect_a(term_connect_a), .term_connect_b(term_connect_b),
	.term_connect_c(term_connect_c), .term_connect_d(term_connect_d),
	.eq_high_a(eq_high_a), .eq_high_b(eq_high_b), .eq_high_c(eq_high_c),
	.eq_high_d(eq_high_d), .preemph_level(preemph_level),
	.output_term_on(output_term_on), .output_current_sel(output_current_sel)
);

// ===== hdl/vswitch_cfg_pkg.sv
// constants and carrier types for the video switch configuration registers
// assumes a 250 MHz system clock and a register port fed by a serial engine
package vswitch_cfg_pkg;

	// ----------------------------------------------------------------------
	// register offsets, in the serial register map
	// ----------------------------------------------------------------------
	localparam logic [7:0] OFS_HS_MODE   = 8'h00;
	localparam logic [7:0] OFS_AUX_MODE  = 8'h01;
	localparam logic [7:0] OFS_RX_SET    = 8'h10;
	localparam logic [7:0] OFS_PULSE_LO  = 8'h11;
	localparam logic [7:0] OFS_PULSE_HI  = 8'h12;
	localparam logic [7:0] OFS_EQ_LO     = 8'h13;
	localparam logic [7:0] OFS_EQ_HI     = 8'h14;
	localparam logic [7:0] OFS_TX_SET    = 8'h20;

	// ----------------------------------------------------------------------
	// storage index of each register
	// ----------------------------------------------------------------------
	localparam int NUM_REGS = 8;
	localparam logic [2:0] IDX_HS_MODE  = 3'h0;
	localparam logic [2:0] IDX_AUX_MODE = 3'h1;
	localparam logic [2:0] IDX_RX_SET   = 3'h2;
	localparam logic [2:0] IDX_PULSE_LO = 3'h3;
	localparam logic [2:0] IDX_PULSE_HI = 3'h4;
	localparam logic [2:0] IDX_EQ_LO    = 3'h5;
	localparam logic [2:0] IDX_EQ_HI    = 3'h6;
	localparam logic [2:0] IDX_TX_SET   = 3'h7;

	// ----------------------------------------------------------------------
	// values after reset and writable bits, by index
	// ----------------------------------------------------------------------
	localparam logic [7:0] RST_VAL [NUM_REGS] = '{8'h40, 8'h40, 8'h01, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h03};
	localparam logic [7:0] WR_MASK [NUM_REGS] = '{8'h43, 8'h43, 8'h01, 8'hFF,
		8'hFF, 8'hFF, 8'hFF, 8'h0F};

	// ----------------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------------
	localparam int POS_ENABLE    = 6;
	localparam int POS_SRC       = 0;
	localparam int POS_TERM_ON   = 0;
	localparam int POS_PREEMPH   = 2;
	localparam int POS_OUT_TERM  = 1;
	localparam int POS_OUT_CURR  = 0;

	// ----------------------------------------------------------------------
	// lane groups and their base bit in the 16-bit lane vectors
	// ----------------------------------------------------------------------
	localparam logic [1:0] GRP_A = 2'h0;
	localparam logic [1:0] GRP_B = 2'h1;
	localparam logic [1:0] GRP_C = 2'h2;
	localparam logic [1:0] GRP_D = 2'h3;
	localparam logic [3:0] BASE_A_UP   = 4'h4;
	localparam logic [3:0] BASE_B_UP   = 4'h0;
	localparam logic [3:0] BASE_C_DOWN = 4'hB;
	localparam logic [3:0] BASE_D_DOWN = 4'hF;

	// ----------------------------------------------------------------------
	// termination pulse timing
	// ----------------------------------------------------------------------
	localparam int CLK_MHZ        = 250;
	localparam int PULSE_MS       = 100;
	// a millisecond is CLK_MHZ * 1000 cycles; no larger factor, so the int never overflows
	localparam int PULSE_CYCLES   = PULSE_MS * 1000 * CLK_MHZ;
	localparam int PULSE_CNT_W    = 25;

	typedef enum logic [0:0]
	{
		PULSE_IDLE = 1'b0,
		PULSE_OPEN = 1'b1
	} pulse_state_e;

	// effective configuration carried as one word
	typedef struct packed
	{
		logic        hs_enable;
		logic [1:0]  hs_source_sel;
		logic        aux_enable;
		logic [1:0]  aux_source_sel;
		logic        input_term_on;
		logic [15:0] term_pulse_sel;
		logic [15:0] eq_level_sel;
		logic [1:0]  preemph_level;
		logic        output_term_on;
		logic        output_current_sel;
	} cfg_s;

endpackage

// ===== hdl/vswitch_cfg_regs.sv
// configuration register bank of a four-input one-output video switch
// assumes a serial protocol engine drives the register port synchronously,
// and that strap pins are static board ties, synchronous to clk
`timescale 1ns/1ps

module vswitch_cfg_regs
#(
	parameter int PULSE_LEN = vswitch_cfg_pkg::PULSE_CYCLES
)
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rstn,
	// register port from the serial engine
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	output logic      [7:0]  reg_rdata,
	// strap pins
	input  wire logic        strap_hs_enable,
	input  wire logic [1:0]  strap_source_sel,
	input  wire logic        strap_eq_level,
	input  wire logic [1:0]  strap_preemph_bits,
	input  wire logic        strap_output_term,
	input  wire logic        strap_output_current,
	// switch controls
	output logic             serial_mode,
	output logic             hs_enable,
	output logic      [1:0]  hs_source_sel,
	output logic      [3:0]  aux_connect,
	output logic      [3:0]  term_connect_a,
	output logic      [3:0]  term_connect_b,
	output logic      [3:0]  term_connect_c,
	output logic      [3:0]  term_connect_d,
	output logic      [3:0]  eq_high_a,
	output logic      [3:0]  eq_high_b,
	output logic      [3:0]  eq_high_c,
	output logic      [3:0]  eq_high_d,
	output logic      [1:0]  preemph_level,
	output logic             output_term_on,
	output logic             output_current_sel
);

	// ----------------------------------------------------------------------
	// functions
	// ----------------------------------------------------------------------

	// bit of the 16-bit lane vector that serves a group lane
	function automatic logic [3:0] lane_bit(input logic [1:0] grp, input logic [1:0] lane);
		logic [3:0] idx;
		idx = vswitch_cfg_pkg::BASE_B_UP + {2'h0, lane};
		case (grp)
			vswitch_cfg_pkg::GRP_A: idx = vswitch_cfg_pkg::BASE_A_UP + {2'h0, lane};
			vswitch_cfg_pkg::GRP_B: idx = vswitch_cfg_pkg::BASE_B_UP + {2'h0, lane};
			vswitch_cfg_pkg::GRP_C: idx = vswitch_cfg_pkg::BASE_C_DOWN - {2'h0, lane};
			default:                idx = vswitch_cfg_pkg::BASE_D_DOWN - {2'h0, lane};
		endcase
		return idx;
	endfunction

	// gather the four lanes of one group from a 16-bit lane vector
	function automatic logic [3:0] group_lanes(input logic [15:0] vec, input logic [1:0] grp);
		logic [3:0] res;
		res = 4'h0;
		for (int l = 0; l < 4; l++)
		begin
			res[l] = vec[lane_bit(grp, 2'(l))];
		end
		return res;
	endfunction

	// storage index for an address; valid is low for an unmapped one
	function automatic logic [3:0] addr_index(input logic [7:0] addr);
		logic [3:0] res;
		case (addr)
			vswitch_cfg_pkg::OFS_HS_MODE:  res = {1'b1, vswitch_cfg_pkg::IDX_HS_MODE};
			vswitch_cfg_pkg::OFS_AUX_MODE: res = {1'b1, vswitch_cfg_pkg::IDX_AUX_MODE};
			vswitch_cfg_pkg::OFS_RX_SET:   res = {1'b1, vswitch_cfg_pkg::IDX_RX_SET};
			vswitch_cfg_pkg::OFS_PULSE_LO: res = {1'b1, vswitch_cfg_pkg::IDX_PULSE_LO};
			vswitch_cfg_pkg::OFS_PULSE_HI: res = {1'b1, vswitch_cfg_pkg::IDX_PULSE_HI};
			vswitch_cfg_pkg::OFS_EQ_LO:    res = {1'b1, vswitch_cfg_pkg::IDX_EQ_LO};
			vswitch_cfg_pkg::OFS_EQ_HI:    res = {1'b1, vswitch_cfg_pkg::IDX_EQ_HI};
			vswitch_cfg_pkg::OFS_TX_SET:   res = {1'b1, vswitch_cfg_pkg::IDX_TX_SET};
			default:                       res = 4'h0;
		endcase
		return res;
	endfunction

	// ----------------------------------------------------------------------
	// reset release
	// ----------------------------------------------------------------------
	logic rst_meta_q;
	logic rst_sync_q;

	// asynchronous assert, release through two flops
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end
		else
		begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end

	// ----------------------------------------------------------------------
	// serial registers and access flag
	// ----------------------------------------------------------------------
	logic [7:0] regs_q [vswitch_cfg_pkg::NUM_REGS];
	logic [7:0] regs_d [vswitch_cfg_pkg::NUM_REGS];
	logic       serial_q;
	logic       serial_d;
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;
	logic [3:0] hit;

	// writes keep reserved bits at zero; reads of unmapped offsets give zero
	always_comb
	begin
		hit      = addr_index(reg_addr);
		regs_d   = regs_q;
		rdata_d  = rdata_q;
		serial_d = serial_q | reg_wr | reg_rd;
		if (reg_wr && hit[3])
		begin
			regs_d[hit[2:0]] = reg_wdata & vswitch_cfg_pkg::WR_MASK[hit[2:0]];
		end
		if (reg_rd)
		begin
			rdata_d = hit[3] ? regs_q[hit[2:0]] : 8'h00;
		end
	end

	always_ff @(posedge clk or negedge rst_sync_q)
	begin
		if (!rst_sync_q)
		begin
			regs_q   <= vswitch_cfg_pkg::RST_VAL;
			serial_q <= 1'b0;
			rdata_q  <= 8'h00;
		end
		else
		begin
			regs_q   <= regs_d;
			serial_q <= serial_d;
			rdata_q  <= rdata_d;
		end
	end

	// ----------------------------------------------------------------------
	// effective configuration
	// ----------------------------------------------------------------------
	vswitch_cfg_pkg::cfg_s cfg;

	// straps stand in for the registers until the first serial access
	always_comb
	begin
		if (serial_q)
		begin
			cfg.hs_enable          = regs_q[vswitch_cfg_pkg::IDX_HS_MODE][vswitch_cfg_pkg::POS_ENABLE];
			cfg.hs_source_sel      = regs_q[vswitch_cfg_pkg::IDX_HS_MODE][1:0];
			cfg.aux_enable         = regs_q[vswitch_cfg_pkg::IDX_AUX_MODE][vswitch_cfg_pkg::POS_ENABLE];
			cfg.aux_source_sel     = regs_q[vswitch_cfg_pkg::IDX_AUX_MODE][1:0];
			cfg.input_term_on      = regs_q[vswitch_cfg_pkg::IDX_RX_SET][vswitch_cfg_pkg::POS_TERM_ON];
			cfg.term_pulse_sel     = {regs_q[vswitch_cfg_pkg::IDX_PULSE_HI],
				regs_q[vswitch_cfg_pkg::IDX_PULSE_LO]};
			cfg.eq_level_sel       = {regs_q[vswitch_cfg_pkg::IDX_EQ_HI],
				regs_q[vswitch_cfg_pkg::IDX_EQ_LO]};
			cfg.preemph_level      = regs_q[vswitch_cfg_pkg::IDX_TX_SET][3:2];
			cfg.output_term_on     = regs_q[vswitch_cfg_pkg::IDX_TX_SET][vswitch_cfg_pkg::POS_OUT_TERM];
			cfg.output_current_sel = regs_q[vswitch_cfg_pkg::IDX_TX_SET][vswitch_cfg_pkg::POS_OUT_CURR];
		end
		else
		begin
			cfg.hs_enable          = strap_hs_enable;
			cfg.hs_source_sel      = strap_source_sel;
			cfg.aux_enable         = 1'b1;
			cfg.aux_source_sel     = strap_source_sel;
			cfg.input_term_on      = 1'b1;
			cfg.term_pulse_sel     = 16'h0000;
			cfg.eq_level_sel       = {16{strap_eq_level}};
			cfg.preemph_level      = strap_preemph_bits;
			cfg.output_term_on     = strap_output_term;
			cfg.output_current_sel = strap_output_current;
		end
	end

	// ----------------------------------------------------------------------
	// termination pulse on source switch
	// ----------------------------------------------------------------------
	vswitch_cfg_pkg::pulse_state_e pst_q;
	vswitch_cfg_pkg::pulse_state_e pst_d;
	logic [vswitch_cfg_pkg::PULSE_CNT_W-1:0] pcnt_q;
	logic [vswitch_cfg_pkg::PULSE_CNT_W-1:0] pcnt_d;
	logic [1:0] src_seen_q;
	logic [1:0] src_seen_d;

	// a new switch during a pulse restarts the full open time
	always_comb
	begin
		src_seen_d = cfg.hs_source_sel;
		pst_d      = pst_q;
		pcnt_d     = pcnt_q;
		if (cfg.hs_source_sel != src_seen_q)
		begin
			pst_d  = vswitch_cfg_pkg::PULSE_OPEN;
			pcnt_d = vswitch_cfg_pkg::PULSE_CNT_W'(PULSE_LEN - 1);
		end
		else
		begin
			case (pst_q)
				vswitch_cfg_pkg::PULSE_IDLE: pst_d = vswitch_cfg_pkg::PULSE_IDLE;
				vswitch_cfg_pkg::PULSE_OPEN:
				begin
					if (pcnt_q == '0)
					begin
						pst_d = vswitch_cfg_pkg::PULSE_IDLE;
					end
					else
					begin
						pcnt_d = pcnt_q - 1'b1;
					end
				end
				default: pst_d = vswitch_cfg_pkg::PULSE_IDLE;
			endcase
		end
	end

	// source tracking starts at code 0; the pulse bits are zero after reset
	always_ff @(posedge clk or negedge rst_sync_q)
	begin
		if (!rst_sync_q)
		begin
			pst_q      <= vswitch_cfg_pkg::PULSE_IDLE;
			pcnt_q     <= '0;
			src_seen_q <= 2'h0;
		end
		else
		begin
			pst_q      <= pst_d;
			pcnt_q     <= pcnt_d;
			src_seen_q <= src_seen_d;
		end
	end

	// ----------------------------------------------------------------------
	// output registers
	// ----------------------------------------------------------------------
	logic [15:0] lane_term;
	logic [3:0]  aux_onehot;
	logic [55:0] out_d;
	logic [55:0] out_q;

	// per-lane termination, aux one-hot and every output flop input
	always_comb
	begin
		for (int b = 0; b < 16; b++)
		begin
			lane_term[b] = cfg.input_term_on
				& ~((pst_q == vswitch_cfg_pkg::PULSE_OPEN) & cfg.term_pulse_sel[b]);
		end
		aux_onehot = 4'h0;
		aux_onehot[cfg.aux_source_sel] = cfg.aux_enable;
		out_d = {cfg.hs_enable, cfg.hs_source_sel, aux_onehot,
			group_lanes(lane_term, vswitch_cfg_pkg::GRP_A),
			group_lanes(lane_term, vswitch_cfg_pkg::GRP_B),
			group_lanes(lane_term, vswitch_cfg_pkg::GRP_C),
			group_lanes(lane_term, vswitch_cfg_pkg::GRP_D),
			group_lanes(cfg.eq_level_sel, vswitch_cfg_pkg::GRP_A),
			group_lanes(cfg.eq_level_sel, vswitch_cfg_pkg::GRP_B),
			group_lanes(cfg.eq_level_sel, vswitch_cfg_pkg::GRP_C),
			group_lanes(cfg.eq_level_sel, vswitch_cfg_pkg::GRP_D),
			cfg.preemph_level,
			cfg.output_term_on,
			cfg.output_current_sel,
			serial_q, 12'h000};
	end

	// outputs lag the configuration by one clock
	always_ff @(posedge clk or negedge rst_sync_q)
	begin
		if (!rst_sync_q)
		begin
			out_q <= '0;
		end
		else
		begin
			out_q <= out_d;
		end
	end

	assign hs_enable          = out_q[55];
	assign hs_source_sel      = out_q[54:53];
	assign aux_connect        = out_q[52:49];
	assign term_connect_a     = out_q[48:45];
	assign term_connect_b     = out_q[44:41];
	assign term_connect_c     = out_q[40:37];
	assign term_connect_d     = out_q[36:33];
	assign eq_high_a          = out_q[32:29];
	assign eq_high_b          = out_q[28:25];
	assign eq_high_c          = out_q[24:21];
	assign eq_high_d          = out_q[20:17];
	assign preemph_level      = out_q[16:15];
	assign output_term_on     = out_q[14];
	assign output_current_sel = out_q[13];
	assign serial_mode        = out_q[12];
	assign reg_rdata          = rdata_q;

endmodule // vswitch_cfg_regs
